// ### hw/cibc_consts.vh
/*
  Constants for the processor-to-expansion-bus control block: default wait
  states, coprocessor decode range and clock divider ratios.
  Assumes a 100 MHz system clock standing in for the 32 MHz master input.
*/
`ifndef CIBC_CONSTS_VH
`define CIBC_CONSTS_VH

// ----------------------------------------------------------------------
// Default wait states, in expansion-bus clock cycles
// ----------------------------------------------------------------------
`define CIBC_WS_MEM8 4'h4
`define CIBC_WS_MEM16 4'h1
`define CIBC_WS_IO8 4'h4
`define CIBC_WS_IO16 4'h1
`define CIBC_WS_IACK 4'h4
`define CIBC_CMD_DELAY 4'h1

// ----------------------------------------------------------------------
// Coprocessor I/O window
// ----------------------------------------------------------------------
`define CIBC_COP_BASE 16'h00f0
`define CIBC_COP_MASK 16'hfff0

// ----------------------------------------------------------------------
// Clock ratios: master edges per half period of each derived clock
// ----------------------------------------------------------------------
`define CIBC_PCLK_HALF_FAST 3'h1
`define CIBC_PCLK_HALF_SLOW 3'h2
`define CIBC_SCLK_HALF 3'h2

`endif

// ### hw/cibc_clock_div.v
/*
  Glitch-free clock divider: a toggling output whose half period is chosen
  by a select input that is only adopted at a completed low phase.
  Assumes the select is synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module cibc_clock_div #(
  parameter W = 3
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [W-1:0] halfFast,
  input wire [W-1:0] halfSlow,
  input wire selSlow,
  output reg clkOut,
  output reg rise,
  output reg slowNow
) ;
  reg [W-1:0] count;
  wire [W-1:0] halfNow;

  assign halfNow = slowNow ? halfSlow : halfFast;

  // The ratio changes only when a low phase has just finished, so no
  // phase of either speed is ever cut short.
  always @(posedge clk) begin
    if (rst) begin
      count <= {W{1'b0}};
      clkOut <= 1'b0;
      rise <= 1'b0;
      slowNow <= 1'b0;
    end else if (ce) begin
      rise <= 1'b0;
      if (count == halfNow - {{(W-1){1'b0}}, 1'b1}) begin
        count <= {W{1'b0}};
        clkOut <= ~clkOut;
        if (!clkOut) begin
          rise <= 1'b1;
          slowNow <= selSlow;
        end
      end else begin
        count <= count + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // cibc_clock_div

`default_nettype wire

// ### hw/cibc_bus_control.v
/*
  Bus control between the processor local bus and the expansion bus:
  command decode, wait-state timing, coprocessor decode and relay, and
  generation of the processor and expansion-bus clocks.
  Assumes all inputs are synchronous to clk; clk stands for the master
  clock input. Active-low pins are modelled as active-low signals.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cibc_consts.vh"

// Contract
// - Processor cycle-type bits decode into the five command strobes.
// - Waits are 4 on 8-bit and IACK, 1 on 16-bit, delay on all but 16-bit memory.
// - A low ready input stretches the cycle until it returns high.
// - A zero-wait request ends the cycle before the default count.
// - I/O accesses to 00F0h-00FFh select the coprocessor; reset is driven.
// - Coprocessor operand request, busy and error pass to the processor.
// - The processor clock runs at half or a quarter of the master rate as speed select asks.
// - An expansion-bus clock at a quarter of the master rate is generated.
// - A speed change of the processor clock never shortens a phase.
module cibc_bus_control (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire cpuStart,
  input wire cpuWriteNotRead,
  input wire cpuDataNotCtrl,
  input wire cpuMemNotIo,
  input wire cpu16Bit,
  input wire [15:0] cpuAddr,
  input wire speedSlow,
  input wire ioChRdy,
  input wire zeroWs_n,
  input wire copBusy_n,
  input wire copError_n,
  input wire coproc_operand_request,
  input wire sysReset,
  output reg cpuReady,
  output reg memRead_n,
  output reg memWrite_n,
  output reg ioRead_n,
  output reg ioWrite_n,
  output reg interrupt_ack_strobe_n,
  output reg copSelect_n,
  output reg copReset,
  output reg cpuBusy_n,
  output reg cpuError_n,
  output reg cpuOperandRequest,
  output reg processor_clock_out,
  output reg expansion_clock_out,
  output reg cycleActive
);

  // --------------------------------------------------------------------
  // Cycle states
  // --------------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_DELAY = 2'h1;
  localparam ST_CMD = 2'h2;
  localparam ST_END = 2'h3;

  localparam CMD_NONE = 3'h0;
  localparam CMD_MRD = 3'h1;
  localparam CMD_MWR = 3'h2;
  localparam CMD_IRD = 3'h3;
  localparam CMD_IWR = 3'h4;
  localparam CMD_IACK = 3'h5;

  reg [1:0] state;
  reg [2:0] cmd;
  reg [3:0] count;
  reg [3:0] waits;
  reg skipDelay;
  reg [2:0] next_cmd;
  reg [3:0] next_waits;
  reg next_skip;
  wire pclk;
  wire sclk;
  wire sRise;

  // --------------------------------------------------------------------
  // Clock generation
  // --------------------------------------------------------------------
  cibc_clock_div #(.W(3)) procDiv (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .halfFast(`CIBC_PCLK_HALF_FAST),
    .halfSlow(`CIBC_PCLK_HALF_SLOW),
    .selSlow(speedSlow),
    .clkOut(pclk),
    .rise(),
    .slowNow()
  );

  cibc_clock_div #(.W(3)) sysDiv (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .halfFast(`CIBC_SCLK_HALF),
    .halfSlow(`CIBC_SCLK_HALF),
    .selSlow(1'b0),
    .clkOut(sclk),
    .rise(sRise),
    .slowNow()
  );

  // --------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------
  always @* begin
    next_cmd = CMD_NONE;
    next_waits = `CIBC_WS_IACK;
    next_skip = 1'b0;
    case ({cpuMemNotIo, cpuDataNotCtrl, cpuWriteNotRead})
      3'b110: begin
        next_cmd = CMD_MRD;
        next_waits = cpu16Bit ? `CIBC_WS_MEM16 : `CIBC_WS_MEM8;
        next_skip = cpu16Bit;
      end
      3'b111: begin
        next_cmd = CMD_MWR;
        next_waits = cpu16Bit ? `CIBC_WS_MEM16 : `CIBC_WS_MEM8;
        next_skip = cpu16Bit;
      end
      3'b010: begin
        next_cmd = CMD_IRD;
        next_waits = cpu16Bit ? `CIBC_WS_IO16 : `CIBC_WS_IO8;
      end
      3'b011: begin
        next_cmd = CMD_IWR;
        next_waits = cpu16Bit ? `CIBC_WS_IO16 : `CIBC_WS_IO8;
      end
      3'b000: begin
        next_cmd = CMD_IACK;
      end
      default: begin
        next_cmd = CMD_NONE;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Cycle sequencer, delay and command states stepped on expansion-clock rising edges
  // --------------------------------------------------------------------
  // A request arriving between expansion edges is latched at once so the
  // processor may drop its start pulse after one clock.
  always @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      cmd <= CMD_NONE;
      count <= 4'h0;
      waits <= 4'h0;
      skipDelay <= 1'b0;
      cpuReady <= 1'b0;
      cycleActive <= 1'b0;
      memRead_n <= 1'b1;
      memWrite_n <= 1'b1;
      ioRead_n <= 1'b1;
      ioWrite_n <= 1'b1;
      interrupt_ack_strobe_n <= 1'b1;
    end else if (ce) begin
      cpuReady <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cpuStart && next_cmd != CMD_NONE) begin
            cmd <= next_cmd;
            waits <= next_waits;
            skipDelay <= next_skip;
            count <= 4'h0;
            cycleActive <= 1'b1;
            state <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (sRise) begin
            if (skipDelay || count == `CIBC_CMD_DELAY) begin
              count <= 4'h0;
              state <= ST_CMD;
              memRead_n <= ~(cmd == CMD_MRD);
              memWrite_n <= ~(cmd == CMD_MWR);
              ioRead_n <= ~(cmd == CMD_IRD);
              ioWrite_n <= ~(cmd == CMD_IWR);
              interrupt_ack_strobe_n <= ~(cmd == CMD_IACK);
            end else begin
              count <= count + 4'h1;
            end
          end
        end
        ST_CMD: begin
          if (sRise) begin
            // Ready low holds the cycle even over a zero-wait request.
            if (ioChRdy && (!zeroWs_n || count >= waits)) begin
              state <= ST_END;
              memRead_n <= 1'b1;
              memWrite_n <= 1'b1;
              ioRead_n <= 1'b1;
              ioWrite_n <= 1'b1;
              interrupt_ack_strobe_n <= 1'b1;
            end else if (count != 4'hf) begin
              count <= count + 4'h1;
            end
          end
        end
        ST_END: begin
          cpuReady <= 1'b1;
          cycleActive <= 1'b0;
          cmd <= CMD_NONE;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Coprocessor decode and relay, and clock outputs
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      copSelect_n <= 1'b1;
      copReset <= 1'b1;
      cpuBusy_n <= 1'b1;
      cpuError_n <= 1'b1;
      cpuOperandRequest <= 1'b0;
      processor_clock_out <= 1'b0;
      expansion_clock_out <= 1'b0;
    end else if (ce) begin
      copSelect_n <= ~(cpuStart && !cpuMemNotIo && cpuDataNotCtrl &&
        ((cpuAddr & `CIBC_COP_MASK) == `CIBC_COP_BASE));
      copReset <= sysReset;
      cpuBusy_n <= copBusy_n;
      cpuError_n <= copError_n;
      cpuOperandRequest <= coproc_operand_request;
      processor_clock_out <= pclk;
      expansion_clock_out <= sclk;
    end
  end

endmodule // cibc_bus_control

`default_nettype wire

// ### sim/cibc_bus_properties.sv
/* Port checker for cibc_bus_control, bound to every instance.
   Assumes one clock, a synchronous active-high reset and ce held high. */
`timescale 1ns/1ps
`default_nettype none
module cibc_bus_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic cpuStart,
  input wire logic cpuWriteNotRead,
  input wire logic cpuDataNotCtrl,
  input wire logic cpuMemNotIo,
  input wire logic [15:0] cpuAddr,
  input wire logic speedSlow,
  input wire logic ioChRdy,
  input wire logic cpuReady,
  input wire logic memRead_n,
  input wire logic memWrite_n,
  input wire logic ioRead_n,
  input wire logic ioWrite_n,
  input wire logic interrupt_ack_strobe_n,
  input wire logic copSelect_n,
  input wire logic processor_clock_out,
  input wire logic expansion_clock_out,
  input wire logic cycleActive
);
  wire logic [4:0] strb;
  wire logic low;
  assign strb = {interrupt_ack_strobe_n, ioWrite_n, ioRead_n, memWrite_n,
    memRead_n};
  assign low = strb != 5'h1f;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_one_strobe: assert property ($countones(~strb) < 2)
    else $error("two command strobes low");
  a_start_taken: assert property (cpuStart && !cycleActive && !cpuReady
    && (cpuDataNotCtrl || !cpuMemNotIo && !cpuWriteNotRead) |=> cycleActive)
    else $error("valid start not taken");
  a_ready_pulse: assert property (cpuReady |-> !cycleActive ##1 !cpuReady)
    else $error("ready not a single pulse");
  a_release_ready: assert property ($fell(low) |=> cpuReady)
    else $error("no ready after strobe release");
  // Six samples cover a full expansion cycle plus one sampling stage.
  a_rdy_stretch: assert property (low && !ioChRdy ##1 (!ioChRdy)[*5]
    |-> low) else $error("strobe ended while not ready");
  a_cop_select: assert property (cpuStart && !cpuMemNotIo && cpuDataNotCtrl
    && cpuAddr[15:4] == 12'h00f |=> !copSelect_n)
    else $error("coprocessor select missing");
  a_exp_clk: assert property ($changed(expansion_clock_out) |=>
    $stable(expansion_clock_out) ##1 $changed(expansion_clock_out))
    else $error("expansion clock period wrong");
  a_pclk_fast: assert property ((!speedSlow)[*8] |->
    $changed(processor_clock_out)) else $error("fast clock not toggling");
  a_pclk_slow: assert property (speedSlow[*8] ##0
    $changed(processor_clock_out) |=> $stable(processor_clock_out))
    else $error("slow clock phase too short");
  // A period never mixes the two speeds, so neither phase is cut short.
  a_fast_period: assert property ($rose(processor_clock_out) ##1
    $fell(processor_clock_out) |=> $rose(processor_clock_out))
    else $error("fast clock period uneven");
  a_slow_period: assert property ($rose(processor_clock_out) ##1
    $stable(processor_clock_out) ##1 $fell(processor_clock_out) |=>
    $stable(processor_clock_out) ##1 $rose(processor_clock_out))
    else $error("slow clock period uneven");
endmodule // cibc_bus_properties
bind cibc_bus_control cibc_bus_properties u_props (
  .clk(clk),
  .rst(rst),
  .cpuStart(cpuStart),
  .cpuWriteNotRead(cpuWriteNotRead),
  .cpuDataNotCtrl(cpuDataNotCtrl),
  .cpuMemNotIo(cpuMemNotIo),
  .cpuAddr(cpuAddr),
  .speedSlow(speedSlow),
  .ioChRdy(ioChRdy),
  .cpuReady(cpuReady),
  .memRead_n(memRead_n),
  .memWrite_n(memWrite_n),
  .ioRead_n(ioRead_n),
  .ioWrite_n(ioWrite_n),
  .interrupt_ack_strobe_n(interrupt_ack_strobe_n),
  .copSelect_n(copSelect_n),
  .processor_clock_out(processor_clock_out),
  .expansion_clock_out(expansion_clock_out),
  .cycleActive(cycleActive)
);
`default_nettype wire

// ### sim/cibc_isa_device.sv
/* Expansion-bus device model: stretches or shortens command strobes.
   Assumes cmdLow is high while any command strobe is asserted. */
`timescale 1ns/1ps
`default_nettype none
module cibc_isa_device (
  input wire logic clk,
  input wire logic cmdLow,
  input wire logic fast,
  input wire logic [7:0] stallLen,
  output logic ioChRdy,
  output logic zeroWs_n
);
  logic [7:0] held = 8'h00;
  always @(posedge clk) held <= cmdLow ? held + 8'h01 : 8'h00;
  // Both lines are open collector with pull-ups, so they idle high.
  assign ioChRdy = !(cmdLow && held < stallLen);
  assign zeroWs_n = !(cmdLow && fast);
endmodule // cibc_isa_device
`default_nettype wire

// ### sim/cpu_to_isa_bus_control_tb_top.sv
/* Self-checking bench for cibc_bus_control with a bus device model.
   Assumes four clk per expansion-bus cycle, as the design is built. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) n_tests++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); num_errors++; end
module cpu_to_isa_bus_control_tb_top;
  logic clk = 1'b0, rst = 1'b1, cpuStart = 1'b0, cpuWriteNotRead = 1'b0;
  logic cpuDataNotCtrl = 1'b0, cpuMemNotIo = 1'b0, cpu16Bit = 1'b0;
  logic speedSlow = 1'b0, copBusy_n = 1'b1, copError_n = 1'b1, fast = 1'b0;
  logic coproc_operand_request = 1'b0, sysReset = 1'b0, sel, exSel;
  logic [15:0] cpuAddr = 16'h0000;
  logic [7:0] stallLen = 8'h00;
  logic [4:0] seen;
  int num_errors = 0, n_tests = 0, wid;
  wire ioChRdy, zeroWs_n, cpuReady, memRead_n, memWrite_n, ioRead_n;
  wire ioWrite_n, interrupt_ack_strobe_n, copSelect_n, copReset, cpuBusy_n;
  wire cpuError_n, cpuOperandRequest, processor_clock_out, cycleActive;
  wire expansion_clock_out;
  wire [4:0] strb = {interrupt_ack_strobe_n, ioWrite_n, ioRead_n,
    memWrite_n, memRead_n};
  // Rows: address, {M/IO, D/C, W/R, 16-bit}, expected strobe mask.
  logic [27:0] rows [9] = '{28'h0000c1e, 28'h0000e1d, 28'h00f341b,
    28'h0100617, 28'h000000f, 28'h0000d1e, 28'h00ff717, 28'h00ef51b,
    28'h00f5f1d};
  always #5 clk = ~clk;
  cibc_bus_control DUT (.ce(1'b1), .*);
  cibc_isa_device farDev (.clk, .cmdLow(strb != 5'h1f), .fast, .stallLen,
    .ioChRdy, .zeroWs_n);
  task automatic wrap_up;
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input logic [27:0] r);
    wid = 0;
    seen = 5'h1f;
    @(negedge clk);
    {cpuAddr, cpuMemNotIo, cpuDataNotCtrl, cpuWriteNotRead, cpu16Bit} =
      r[27:8];
    cpuStart = 1'b1;
    @(negedge clk);
    cpuStart = 1'b0;
    sel = copSelect_n;
    for (int k = 0; k < 300 && cpuReady !== 1'b1; k++) begin
      if (strb != 5'h1f) begin
        wid++;
        seen = strb;
      end
      @(negedge clk);
    end
    `CHK("ready", 1'b1, cpuReady)
    if (cpuReady !== 1'b1) begin
      wrap_up();
    end
  endtask
  task automatic clocks(input logic slow);
    logic [7:0] ph, sh;
    logic okP, okS;
    speedSlow = slow;
    repeat (12) @(negedge clk);
    for (int k = 0; k < 8; k++) begin
      ph[k] = processor_clock_out;
      sh[k] = expansion_clock_out;
      @(negedge clk);
    end
    okP = slow ? (ph == 8'h33 || ph == 8'h66 || ph == 8'hcc || ph == 8'h99)
      : (ph == 8'h55 || ph == 8'haa);
    okS = sh == 8'h33 || sh == 8'h66 || sh == 8'hcc || sh == 8'h99;
    `CHK("pclk", 1'b1, okP)
    `CHK("sclk", 1'b1, okS)
  endtask
  initial begin
    repeat (20) @(negedge clk);
    `CHK("rstStrobes", 5'h1f, strb)
    `CHK("rstCopReset", 1'b1, copReset)
    rst = 1'b0;
    foreach (rows[i]) begin
      cyc(rows[i]);
      exSel = rows[i][11:10] != 2'h1 || rows[i][27:16] != 12'h00f;
      `CHK("strobe", rows[i][4:0], seen)
      `CHK("width", rows[i][8] ? 8 : 20, wid)
      `CHK("select", exSel, sel)
    end
    stallLen = 8'h18;
    cyc(rows[5]);
    `CHK("stretched", 1'b1, wid > 24)
    stallLen = 8'h00;
    fast = 1'b1;
    cyc(rows[2]);
    `CHK("shortened", 1'b1, wid < 20)
    fast = 1'b0;
    // A reset in mid-strobe must leave the bus idle and ready for work.
    @(negedge clk);
    {cpuAddr, cpuMemNotIo, cpuDataNotCtrl, cpuWriteNotRead, cpu16Bit} =
      rows[0][27:8];
    cpuStart = 1'b1;
    @(negedge clk);
    cpuStart = 1'b0;
    repeat (12) @(negedge clk);
    `CHK("midStrobe", rows[0][4:0], strb)
    rst = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("rstStrobes2", 5'h1f, strb)
    `CHK("rstIdle", 1'b0, cycleActive)
    `CHK("rstReady", 1'b0, cpuReady)
    `CHK("rstCopReset2", 1'b1, copReset)
    rst = 1'b0;
    cyc(rows[1]);
    `CHK("afterRst", rows[1][4:0], seen)
    `CHK("afterRstWidth", 20, wid)
    @(negedge clk);
    {cpuMemNotIo, cpuDataNotCtrl, cpuWriteNotRead} = 3'h1;
    cpuStart = 1'b1;
    @(negedge clk);
    cpuStart = 1'b0;
    @(negedge clk);
    `CHK("badType", 1'b0, cycleActive)
    copBusy_n = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("busy", 1'b0, cpuBusy_n)
    `CHK("opReq", 1'b0, cpuOperandRequest)
    copBusy_n = 1'b1;
    coproc_operand_request = 1'b1;
    copError_n = 1'b0;
    sysReset = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("idle", 1'b1, cpuBusy_n)
    `CHK("opReq", 1'b1, cpuOperandRequest)
    `CHK("error", 1'b0, cpuError_n)
    `CHK("copReset", 1'b1, copReset)
    sysReset = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("copReset", 1'b0, copReset)
    clocks(1'b0);
    clocks(1'b1);
    clocks(1'b0);
    wrap_up();
  end
endmodule // cpu_to_isa_bus_control_tb_top
`default_nettype wire
